/* File: src/fault_latch_policy.sv */
module fault_latch_policy (
  // clock and reset
  input  wire logic                        sys_clk_i,
  input  wire logic                        rst_i,
  // avalon-mm slave
  input  wire fault_latch_pkg::avmm_req_t  avmm_req_i,
  output logic [fault_latch_pkg::DATA_W-1:0] avmm_readdata_o,
  output logic                             avmm_waitrequest_o,
  // fault monitors, asynchronous
  input  wire fault_latch_pkg::fault_cond_t cond_i,
  input  wire logic                        open_wiring_i,
  // drive control
  output logic                             out_stage_en_o,
  output logic                             abort_move_o,
  output logic                             fault_summary_o,
  output logic [fault_latch_pkg::OW_W-1:0] open_wire_current_o
);

  localparam int unsigned DW = fault_latch_pkg::DATA_W;

  function automatic logic [DW-1:0] lanes(input logic [DW/8-1:0] be);
    logic [DW-1:0] m;
    m = '0;
    for (int i = 0; i < DW/8; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  // synchronised monitor inputs
  fault_latch_pkg::fault_cond_t cond_s;
  logic                         open_wiring_s;
  logic [$bits(fault_latch_pkg::fault_cond_t):0] sync_q;

  bit_sync #(
    .WIDTH ($bits(fault_latch_pkg::fault_cond_t) + 1)
  ) u_sync (
    .clk_i (sys_clk_i),
    .rst_i (rst_i),
    .d_i   ({cond_i, open_wiring_i}),
    .q_o   (sync_q)
  );

  assign cond_s        = sync_q[$bits(fault_latch_pkg::fault_cond_t):1];
  assign open_wiring_s = sync_q[0];

  logic [DW-1:0] cond_v;
  assign cond_v = fault_latch_pkg::cond_vec(cond_s)
                | (DW'(open_wiring_s) << fault_latch_pkg::B_OPEN_WIR);

  // registers
  logic [DW-1:0]                    mask_reg;
  logic [DW-1:0]                    mask_next;
  logic [DW-1:0]                    latch_reg;
  logic [DW-1:0]                    latch_next;
  logic [fault_latch_pkg::OW_W-1:0] openw_reg;
  logic [fault_latch_pkg::OW_W-1:0] openw_next;
  logic                             follow_d_reg;
  logic                             wait_reg;
  logic [DW-1:0]                    rdata_next;

  // bus decode
  wire           req_any  = avmm_req_i.read | avmm_req_i.write;
  wire           wr_go    = avmm_req_i.write & ~wait_reg;
  wire           sel_mask = avmm_req_i.address == fault_latch_pkg::OFS_MASK;
  wire           sel_lat  = avmm_req_i.address == fault_latch_pkg::OFS_LATCH;
  wire           sel_ev   = avmm_req_i.address == fault_latch_pkg::OFS_EVENT;
  wire           sel_ow   = avmm_req_i.address == fault_latch_pkg::OFS_OPENW;
  wire [DW-1:0]  be_m     = lanes(avmm_req_i.byteenable);
  wire [DW-1:0]  wd_m     = avmm_req_i.writedata & be_m;
  wire           wr_mask  = wr_go & sel_mask;
  wire           wr_lat   = wr_go & sel_lat;
  wire           wr_ow    = wr_go & sel_ow;

  // configuration: only policy bits are writable, reserved stays zero
  wire [DW-1:0] mask_wr = be_m & fault_latch_pkg::LATCH_BITS;
  assign mask_next = wr_mask ? (mask_reg & ~mask_wr) | (wd_m & mask_wr)
                             : mask_reg;

  assign openw_next = wr_ow
    ? (openw_reg & ~be_m[fault_latch_pkg::OW_W-1:0])
      | wd_m[fault_latch_pkg::OW_W-1:0]
    : openw_reg;

  // latch set by enabled sources, write-one clears, set wins
  wire [DW-1:0] lat_set = cond_v & mask_reg
                        & fault_latch_pkg::LATCH_BITS;
  wire [DW-1:0] lat_clr = wr_lat ? wd_m & fault_latch_pkg::LATCH_BITS
                                 : '0;
  assign latch_next = (latch_reg & ~lat_clr) | lat_set;

  // unlatched sources except bits 9 and 10 hold the stage off only while present
  wire auto_dis = |(cond_v & ~mask_reg
                  & fault_latch_pkg::AUTO_BITS);
  // hardware failures and safe torque off always block the stage
  wire hard_dis = |(cond_v & fault_latch_pkg::RO_BITS);
  wire en_next  = ~(|latch_reg) & ~auto_dis & ~hard_dis;
  // unlatched following error aborts the move, stage stays on
  wire abort_next = cond_v[fault_latch_pkg::B_FOLLOW] & ~follow_d_reg
                  & ~mask_reg[fault_latch_pkg::B_FOLLOW];

  // read view: live read-only bits, reserved reads zero
  wire [DW-1:0] fault_rd = latch_reg
                         | (cond_v & fault_latch_pkg::RO_BITS);
  wire [DW-1:0] event_rd =
      (DW'(fault_summary_o) << fault_latch_pkg::B_EV_FAULT)
    | (DW'(out_stage_en_o)  << fault_latch_pkg::B_EV_OUTEN);
  assign rdata_next = sel_mask ? mask_reg
                    : sel_lat  ? fault_rd
                    : sel_ev   ? event_rd
                    : sel_ow   ? DW'(openw_reg)
                    : '0;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mask_reg     <= fault_latch_pkg::MASK_RST;
      latch_reg    <= '0;
      openw_reg    <= fault_latch_pkg::OPENW_RST;
      follow_d_reg <= 1'b0;
    end else begin
      mask_reg     <= mask_next;
      latch_reg    <= latch_next;
      openw_reg    <= openw_next;
      follow_d_reg <= cond_v[fault_latch_pkg::B_FOLLOW];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      out_stage_en_o  <= 1'b0;
      abort_move_o    <= 1'b0;
      fault_summary_o <= 1'b0;
    end else begin
      out_stage_en_o  <= en_next;
      abort_move_o    <= abort_next;
      fault_summary_o <= |latch_next;
    end
  end

  assign open_wire_current_o = openw_reg;

  // one wait cycle, then the access completes
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wait_reg        <= 1'b1;
      avmm_readdata_o <= '0;
    end else begin
      wait_reg <= ~(req_any & wait_reg);
      if (req_any & wait_reg) begin
        avmm_readdata_o <= rdata_next;
      end
    end
  end

  assign avmm_waitrequest_o = wait_reg;

  // checks
  AST_DRV_TEMP_RECOVER: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (latch_reg == '0 && !auto_dis && !hard_dis) |=> out_stage_en_o)
    else $error("stage not re-enabled with no fault present");

  AST_MOTOR_TEMP_LATCH: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (mask_reg[fault_latch_pkg::B_MOT_TEMP]
     && cond_v[fault_latch_pkg::B_MOT_TEMP])
    |=> latch_reg[fault_latch_pkg::B_MOT_TEMP])
    else $error("motor temperature fault not latched");

  AST_OVERVOLT_LATCH: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (mask_reg[fault_latch_pkg::B_OVERVOLT]
     && cond_v[fault_latch_pkg::B_OVERVOLT])
    |=> latch_reg[fault_latch_pkg::B_OVERVOLT] ##1 !out_stage_en_o)
    else $error("overvoltage latch did not disable stage");

  AST_UNDERVOLT_NOLATCH: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (!mask_reg[fault_latch_pkg::B_UNDERVLT]
     && cond_v[fault_latch_pkg::B_UNDERVLT]
     && !latch_reg[fault_latch_pkg::B_UNDERVLT] && !wr_mask)
    |=> !latch_reg[fault_latch_pkg::B_UNDERVLT] && !out_stage_en_o)
    else $error("unlatched undervoltage mishandled");

  AST_FOLLOW_LATCH: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (mask_reg[fault_latch_pkg::B_FOLLOW]
     && cond_v[fault_latch_pkg::B_FOLLOW])
    |=> latch_reg[fault_latch_pkg::B_FOLLOW] ##1 !out_stage_en_o)
    else $error("following error latch did not disable stage");

  AST_FOLLOW_ABORT: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    ($rose(cond_v[fault_latch_pkg::B_FOLLOW])
     && !mask_reg[fault_latch_pkg::B_FOLLOW])
    |=> abort_move_o ##1 !abort_move_o)
    else $error("abort pulse missing or too long");

  AST_RO_BITS: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (latch_reg & fault_latch_pkg::RO_BITS) == '0
    && (mask_reg & fault_latch_pkg::RO_BITS) == '0)
    else $error("read-only fault bit stored from a write");

  AST_RSVD_ZERO: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !mask_reg[fault_latch_pkg::B_RSVD]
    && !latch_reg[fault_latch_pkg::B_RSVD])
    else $error("reserved bit set");

  AST_CLEAR_ONLY_ONES: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    wr_lat |=> ((latch_reg & $past(latch_reg & ~lat_clr))
                == $past(latch_reg & ~lat_clr)))
    else $error("write cleared a bit written as zero");

  AST_SUMMARY_FLAG: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    fault_summary_o == (latch_reg != '0))
    else $error("summary flag disagrees with latched faults");

  AST_LATCH_HOLDS_OFF: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (latch_reg != '0) |=> !out_stage_en_o)
    else $error("stage enabled with latched fault");

  AST_STO_DISABLES: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    cond_v[fault_latch_pkg::B_STO] |=> !out_stage_en_o)
    else $error("stage enabled during safe torque off");

  AST_OPENW_WRITE: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (wr_ow && avmm_req_i.byteenable == 4'hf)
    |=> open_wire_current_o
        == $past(avmm_req_i.writedata[fault_latch_pkg::OW_W-1:0]))
    else $error("open wiring current not stored");

  AST_DRV_TEMP_HOLD: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (!mask_reg[fault_latch_pkg::B_DRV_TEMP]
     && cond_v[fault_latch_pkg::B_DRV_TEMP])
    |=> !out_stage_en_o)
    else $error("stage enabled during drive overtemperature");

  AST_MOTOR_TEMP_NOLATCH: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (!mask_reg[fault_latch_pkg::B_MOT_TEMP]
     && !latch_reg[fault_latch_pkg::B_MOT_TEMP])
    |=> !latch_reg[fault_latch_pkg::B_MOT_TEMP])
    else $error("unlatched motor temperature fault stored");

  AST_OVERVOLT_RECOVER: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    ($fell(cond_v[fault_latch_pkg::B_OVERVOLT])
     && !mask_reg[fault_latch_pkg::B_OVERVOLT]
     && latch_reg == '0 && cond_v == '0)
    |=> out_stage_en_o)
    else $error("stage not re-enabled after overvoltage");

  AST_FEEDBACK_LATCH: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (mask_reg[fault_latch_pkg::B_FEEDBACK]
     && cond_v[fault_latch_pkg::B_FEEDBACK])
    |=> latch_reg[fault_latch_pkg::B_FEEDBACK] ##1 !out_stage_en_o)
    else $error("feedback fault latch did not disable stage");

  AST_PHASING_NOLATCH: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (!mask_reg[fault_latch_pkg::B_PHASING]
     && cond_v[fault_latch_pkg::B_PHASING])
    |=> !out_stage_en_o)
    else $error("stage enabled during phasing error");

  AST_FOLLOW_STAYS_ON: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (!mask_reg[fault_latch_pkg::B_FOLLOW] && latch_reg == '0
     && cond_v == (DW'(1) << fault_latch_pkg::B_FOLLOW))
    |=> out_stage_en_o)
    else $error("unlatched following error disabled stage");

  AST_I2T_LATCH: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (mask_reg[fault_latch_pkg::B_I2T]
     && cond_v[fault_latch_pkg::B_I2T])
    |=> latch_reg[fault_latch_pkg::B_I2T] ##1 !out_stage_en_o)
    else $error("current limit latch did not disable stage");

  AST_LOGIC_FAIL_STOP: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    cond_v[fault_latch_pkg::B_LOGIC] |=> !out_stage_en_o)
    else $error("stage enabled with logic array failure");

  AST_CMD_LOST_LATCH: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (mask_reg[fault_latch_pkg::B_CMD_LOST]
     && cond_v[fault_latch_pkg::B_CMD_LOST])
    |=> latch_reg[fault_latch_pkg::B_CMD_LOST] ##1 !out_stage_en_o)
    else $error("command loss latch did not disable stage");

  AST_HW_INIT_STOP: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    cond_v[fault_latch_pkg::B_HW_INIT] |=> !out_stage_en_o)
    else $error("stage enabled with hardware init failure");

  AST_SAFETY_LATCH: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (mask_reg[fault_latch_pkg::B_SAFETY]
     && cond_v[fault_latch_pkg::B_SAFETY])
    |=> latch_reg[fault_latch_pkg::B_SAFETY] ##1 !out_stage_en_o)
    else $error("safety check latch did not disable stage");

  AST_CUR_CTRL_LATCH: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (mask_reg[fault_latch_pkg::B_CUR_CTRL]
     && cond_v[fault_latch_pkg::B_CUR_CTRL])
    |=> latch_reg[fault_latch_pkg::B_CUR_CTRL] ##1 !out_stage_en_o)
    else $error("current control latch did not disable stage");

  AST_OPEN_WIRE_LATCH: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (mask_reg[fault_latch_pkg::B_OPEN_WIR]
     && cond_v[fault_latch_pkg::B_OPEN_WIR])
    |=> latch_reg[fault_latch_pkg::B_OPEN_WIR] ##1 !out_stage_en_o)
    else $error("open wiring latch did not disable stage");

  AST_SET_WINS: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (wr_lat && lat_set != '0)
    |=> ((latch_reg & $past(lat_set)) == $past(lat_set)))
    else $error("clear in the set cycle dropped a fault");

  AST_MASK_WRITE: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (wr_mask && avmm_req_i.byteenable == 4'hf)
    |=> mask_reg
        == ($past(avmm_req_i.writedata) & fault_latch_pkg::LATCH_BITS))
    else $error("policy mask write stored a wrong value");

  COV_LATCH_CLEAR: cover property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (latch_reg != '0) ##[1:20] (latch_reg == '0));

  COV_ABORT: cover property (
    @(posedge sys_clk_i) disable iff (rst_i) abort_move_o);

  COV_AUTO_RECOVER: cover property (
    @(posedge sys_clk_i) disable iff (rst_i)
    auto_dis ##1 !auto_dis ##2 out_stage_en_o);

  COV_READ: cover property (
    @(posedge sys_clk_i) disable iff (rst_i)
    avmm_req_i.read && !wait_reg && sel_lat);

endmodule

/* File: src/fault_latch_pkg.sv */
// Notes on behaviour
// - drive overtemp unlatched: re-enable once cooled
// - bit4 selects latch or recover, motor temp
// - bit5 selects latch or recover, overvoltage
// - bit6 selects latch or recover, undervoltage
// - bit7 latches feedback faults
// - bit8 selects latch or recover, phasing error
// - bit9 set: following error latches, disables
// - bit9 clear: abort move, stay enabled
// - bit10 latches on current-squared-time limiting
// - bit11 logic array failure, read-only
// - bit12 latches on command input loss
// - bit13 hardware init failure, read-only
// - bit14 latches safety consistency failure
// - bit15 latches loss of current control
// - bit16 latches open wiring, configurable current
// - bit18 shows safe torque off active
// - writing one clears only that fault
// - any latched fault sets event bit22
package fault_latch_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned OW_W   = 16;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_MASK   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_LATCH  = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_EVENT  = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_OPENW  = 4'hc;

  // fault word bit positions
  localparam int unsigned B_DRV_TEMP = 3;
  localparam int unsigned B_MOT_TEMP = 4;
  localparam int unsigned B_OVERVOLT = 5;
  localparam int unsigned B_UNDERVLT = 6;
  localparam int unsigned B_FEEDBACK = 7;
  localparam int unsigned B_PHASING  = 8;
  localparam int unsigned B_FOLLOW   = 9;
  localparam int unsigned B_I2T      = 10;
  localparam int unsigned B_LOGIC    = 11;
  localparam int unsigned B_CMD_LOST = 12;
  localparam int unsigned B_HW_INIT  = 13;
  localparam int unsigned B_SAFETY   = 14;
  localparam int unsigned B_CUR_CTRL = 15;
  localparam int unsigned B_OPEN_WIR = 16;
  localparam int unsigned B_RSVD     = 17;
  localparam int unsigned B_STO      = 18;

  // event word bit positions
  localparam int unsigned B_EV_OUTEN = 0;
  localparam int unsigned B_EV_FAULT = 22;

  // bit groups of the fault word
  localparam logic [DATA_W-1:0] LATCH_BITS = 32'h0001_d7f8;
  localparam logic [DATA_W-1:0] AUTO_BITS  = 32'h0001_d1f8;
  localparam logic [DATA_W-1:0] RO_BITS    = 32'h0004_2800;

  // reset values
  localparam logic [DATA_W-1:0] MASK_RST  = 32'h0000_0000;
  localparam logic [OW_W-1:0]   OPENW_RST = 16'h0000;

  typedef struct packed {
    logic                read;
    logic                write;
    logic [ADDR_W-1:0]   address;
    logic [DATA_W-1:0]   writedata;
    logic [DATA_W/8-1:0] byteenable;
  } avmm_req_t;

  typedef struct packed {
    logic sto;
    logic cur_ctrl;
    logic safety;
    logic hw_init;
    logic cmd_lost;
    logic logic_fail;
    logic i2t;
    logic follow;
    logic phasing;
    logic feedback;
    logic undervolt;
    logic overvolt;
    logic motor_temp;
    logic drive_temp;
  } fault_cond_t;

  // place each monitor condition at its fault word position
  function automatic logic [DATA_W-1:0] cond_vec(input fault_cond_t c);
    logic [DATA_W-1:0] v;
    v             = '0;
    v[B_DRV_TEMP] = c.drive_temp;
    v[B_MOT_TEMP] = c.motor_temp;
    v[B_OVERVOLT] = c.overvolt;
    v[B_UNDERVLT] = c.undervolt;
    v[B_FEEDBACK] = c.feedback;
    v[B_PHASING]  = c.phasing;
    v[B_FOLLOW]   = c.follow;
    v[B_I2T]      = c.i2t;
    v[B_LOGIC]    = c.logic_fail;
    v[B_CMD_LOST] = c.cmd_lost;
    v[B_HW_INIT]  = c.hw_init;
    v[B_SAFETY]   = c.safety;
    v[B_CUR_CTRL] = c.cur_ctrl;
    v[B_OPEN_WIR] = 1'b0;
    v[B_STO]      = c.sto;
    return v;
  endfunction

endpackage

/* File: src/bit_sync.sv */
module bit_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // data
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_reg;

  // first stage is read only by the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_o      <= '0;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end

endmodule

/* File: src/fault_latch_pkg_fix.sv */
// intentionally empty

/* File: test/fault_monitor_model.sv */
module fault_monitor_model (
  // clock
  input  wire logic                    sys_clk_i,
  // wanted levels, by fault word position
  input  wire logic [31:0]             lvl_i,
  // monitor levels
  output fault_latch_pkg::fault_cond_t cond_o,
  output logic                         open_wiring_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // struct order runs from the top: 18, then 15 down to 3
  always_ff @(posedge sys_clk_i) begin
    cond_o        <= {lvl_i[18], lvl_i[15:3]};
    open_wiring_o <= lvl_i[16];
  end
endmodule

/* File: test/tb_fault_latch_policy.sv */
module tb_fault_latch_policy;
  timeunit 1ns;
  timeprecision 1ps;
  logic                         sys_clk_i;
  logic                         rst_i;
  fault_latch_pkg::avmm_req_t   req;
  logic [31:0]                  rdata;
  logic                         wait_req;
  logic [31:0]                  lvl;
  fault_latch_pkg::fault_cond_t cond;
  logic                         open_wiring;
  logic                         out_en;
  logic                         abort;
  logic                         summary;
  logic [15:0]                  ow_cur;
  logic [31:0]                  exp_q[$];
  int                           failures;
  int                           checks;
  int                           aborts;

  fault_monitor_model mon_u (
    .sys_clk_i     (sys_clk_i),
    .lvl_i         (lvl),
    .cond_o        (cond),
    .open_wiring_o (open_wiring)
  );

  fault_latch_policy dut_u (
    .sys_clk_i           (sys_clk_i),
    .rst_i               (rst_i),
    .avmm_req_i          (req),
    .avmm_readdata_o     (rdata),
    .avmm_waitrequest_o  (wait_req),
    .cond_i              (cond),
    .open_wiring_i       (open_wiring),
    .out_stage_en_o      (out_en),
    .abort_move_o        (abort),
    .fault_summary_o     (summary),
    .open_wire_current_o (ow_cur)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk_i);
    req.read      <= ~wr;
    req.write     <= wr;
    req.address   <= a;
    req.writedata <= d;
    do begin
      @(posedge sys_clk_i);
    end while (wait_req !== 1'b0);
    req.read  <= 1'b0;
    req.write <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  // read results are taken off the queue as they appear
  always @(posedge sys_clk_i) begin
    if (req.read && wait_req === 1'b0) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("[FAIL] readdata expected nothing seen %h", rdata);
      end else begin
        chk("readdata", exp_q.pop_front(), rdata);
      end
    end
    if (abort === 1'b1) aborts++;
  end

  // one source, latched or self-recovering
  task automatic policy(input int b, input logic lat);
    logic [31:0] v;
    logic        stay;
    int          a0;
    v    = 32'h1 << b;
    stay = ~lat && (b == 9 || b == 10);
    wr(fault_latch_pkg::OFS_MASK, lat ? v : 32'h0);
    a0 = aborts;
    lvl[b] <= 1'b1;
    tick(6);
    chk("out_stage_en", {31'h0, stay}, out_en);
    chk("fault_summary", {31'h0, lat}, summary);
    rd(fault_latch_pkg::OFS_LATCH, lat ? v : 32'h0);
    lvl[b] <= 1'b0;
    tick(6);
    chk("out_stage_en", {31'h0, ~lat}, out_en);
    chk("aborts", 32'(a0 + ((~lat && b == 9) ? 1 : 0)), 32'(aborts));
    if (lat) begin
      rd(fault_latch_pkg::OFS_EVENT, 32'h0040_0000);
      wr(fault_latch_pkg::OFS_LATCH, v);
      tick(6);
      chk("out_stage_en", 32'h1, out_en);
      rd(fault_latch_pkg::OFS_LATCH, 32'h0);
    end
  endtask

  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    results();
  end

  initial begin
    logic [31:0] m;
    logic [31:0] c;
    rst_i = 1'b1;
    req = '0;
    req.byteenable = 4'hf;
    lvl = 32'h0;
    failures = 0;
    checks = 0;
    aborts = 0;
    void'($urandom(53996));
    tick(2);
    rst_i <= 1'b0;
    tick(4);
    chk("out_stage_en", 32'h1, out_en);
    rd(fault_latch_pkg::OFS_MASK, 32'h0);
    rd(fault_latch_pkg::OFS_LATCH, 32'h0);
    rd(fault_latch_pkg::OFS_EVENT, 32'h1);
    rd(4'h2, 32'h0);
    $display("test reset done");
    for (int b = 3; b <= 16; b++) begin
      if (fault_latch_pkg::LATCH_BITS[b]) begin
        policy(b, 1'b1);
        policy(b, 1'b0);
      end
    end
    $display("test policy done");
    for (int b = 11; b <= 18; b++) begin
      if (fault_latch_pkg::RO_BITS[b]) begin
        lvl[b] <= 1'b1;
        tick(6);
        chk("out_stage_en", 32'h0, out_en);
        wr(fault_latch_pkg::OFS_LATCH, 32'h1 << b);
        rd(fault_latch_pkg::OFS_LATCH, 32'h1 << b);
        lvl[b] <= 1'b0;
        tick(6);
        rd(fault_latch_pkg::OFS_LATCH, 32'h0);
      end
    end
    wr(fault_latch_pkg::OFS_MASK, 32'hffff_ffff);
    wr(4'h2, 32'h0);
    rd(fault_latch_pkg::OFS_MASK, fault_latch_pkg::LATCH_BITS);
    $display("test read-only done");
    m = $urandom() & fault_latch_pkg::LATCH_BITS;
    c = $urandom();
    wr(fault_latch_pkg::OFS_MASK, m);
    lvl <= m;
    tick(6);
    lvl <= 32'h0;
    tick(6);
    rd(fault_latch_pkg::OFS_LATCH, m);
    wr(fault_latch_pkg::OFS_LATCH, c);
    rd(fault_latch_pkg::OFS_LATCH, m & ~c);
    wr(fault_latch_pkg::OFS_LATCH, 32'hffff_ffff);
    rd(fault_latch_pkg::OFS_LATCH, 32'h0);
    $display("test clear done");
    m = $urandom();
    wr(fault_latch_pkg::OFS_OPENW, m);
    rd(fault_latch_pkg::OFS_OPENW, {16'h0, m[15:0]});
    chk("open_wire_current", {16'h0, m[15:0]}, {16'h0, ow_cur});
    $display("test open wiring current done");
    tick(4);
    chk("queue left", 32'h0, 32'(exp_q.size()));
    results();
  end
endmodule
